// *** verilog/current_limit_regs.vh ***
// Register offsets, field positions, reset values and timing counts for the
// motor current limit protection block.
// Assumes a 32-bit APB slave with word aligned registers.
`ifndef CURRENT_LIMIT_REGS_VH
`define CURRENT_LIMIT_REGS_VH

// Byte offsets of the registers.
`define OC_LEVEL_OFS 12'h000
`define OC_DELAY_OFS 12'h004
`define UC_LEVEL_OFS 12'h008
`define UC_DELAY_OFS 12'h00C
`define RELAY_CFG_OFS 12'h010
`define STATUS_OFS 12'h014
`define IRQ_STATUS_OFS 12'h018
`define IRQ_MASK_OFS 12'h01C
`define FAULT_CLEAR_OFS 12'h020

// Level settings are in percent of rated full load current; zero means Off.
`define LEVEL_OFF 10'h000
`define OC_LEVEL_MIN 10'h032
`define OC_LEVEL_MAX 10'h320
`define UC_LEVEL_MIN 10'h005
`define UC_LEVEL_MAX 10'h064
`define OC_LEVEL_RST 10'h000
`define UC_LEVEL_RST 10'h000

// Delay settings are in tenths of a second; zero means Off.
`define DELAY_OFF 10'h000
`define DELAY_MIN 10'h001
`define DELAY_MAX 10'h384
`define DELAY_RST 10'h001

// Fault codes reported on the fault code output.
`define FAULT_NONE 8'h00
`define OC_FAULT_CODE 8'h1F
`define UC_FAULT_CODE 8'h22

// Operating state one-hot field positions of the starter state input.
`define ST_UP_TO_SPEED 0
`define ST_ENERGY_SAVER 1
`define ST_CURRENT_FOLLOW 2
`define ST_PHASE_CONTROL 3

// Relay configuration bits: per relay, alarm duty field then fault duty field.
`define RELAY_CNT 6
`define RELAY_ALARM_LSB 0
`define RELAY_FAULT_LSB 8
`define RELAY_CFG_RST 16'h0000

// Interrupt and status bits.
`define EV_OC_ALARM 0
`define EV_UC_ALARM 1
`define EV_OC_TRIP 2
`define EV_UC_TRIP 3

// Delay tick: one step is 0.1 s at a 250 MHz clock.
`define CLK_MHZ 250
`define TICK_US 100000
`define TICK_CYCLES (`CLK_MHZ * `TICK_US)

`endif

// *** verilog/delay_timer.v ***
// One protection delay timer counting in 0.1 second ticks.
// Assumes a tick pulse one clock wide from the parent, on the same clock.
`timescale 1ns/100ps
`include "current_limit_regs.vh"

module delay_timer (
  input wire sys_clk_i, // System clock.
  input wire reset_i, // Synchronous reset, active high.
  input wire breach_i, // Latest cycle average breaches the level.
  input wire tick_i, // Pulse once per 0.1 second.
  input wire [9:0] delay_i, // Delay in tenths of a second, zero is Off.
  output reg expired_o // Pulse when the delay has run out.
);

  reg [9:0] count_reg; // Elapsed tenths of a second.

  // The count restarts the moment the breach ends, so only an unbroken
  // breach can expire it; an Off delay never expires.
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      count_reg <= 10'h000;
      expired_o <= 1'b0;
    end else begin
      expired_o <= 1'b0;
      if (!breach_i || delay_i == `DELAY_OFF) begin
        count_reg <= 10'h000; // see RL17
      end else if (tick_i) begin
        // The first tick lands at any phase of the breach, so one extra
        // tick is waited for: a trip may come up to a step late, never early.
        if (count_reg >= delay_i) begin
          expired_o <= 1'b1; // see RL7
          count_reg <= 10'h000;
        end else begin
          count_reg <= count_reg + 10'h001; // see RL17
        end
      end
    end
  end

endmodule

// *** verilog/current_limit_protect.v ***
// Over and under current protection for a solid state motor starter.
// Assumes an APB master on sys_clk_i, a cycle average current word with a
// once per line cycle strobe from logic on the same clock, and a starter
// state field arriving from another domain.
//
// How it works
// RL1 - Compare average to over level each cycle.
// RL2 - Over current raises alarm and alarm relays.
// RL3 - Over current persisting past delay trips with fault code.
// RL4 - Over check only in running operating states.
// RL5 - Over level Off or 50 to 800 percent.
// RL6 - Over delay Off or 0.1 to 90 seconds.
// RL7 - Trip needs unbroken breach for whole delay.
// RL8 - Off delay: no trip, relays follow alarm.
// RL9 - Operator uses minimum delay for shear pin.
// RL10 - Under level compare raises alarm and relays.
// RL11 - Under current persisting past delay trips.
// RL12 - Under check only in running operating states.
// RL13 - Under level Off or 5 to 100 percent.
// RL14 - Any trip switches all fault duty relays.
// RL15 - Under delay Off or 0.1 to 90 seconds.
// RL16 - Under Off delay: relays follow alarm only.
// RL17 - Timers tick 0.1 s, restart when clear.
// RL18 - Trip latches until external fault clear.
//
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/100ps
`include "current_limit_regs.vh"

module current_limit_protect #(
  parameter [31:0] TICK_CYCLES = `TICK_CYCLES // Clocks per 0.1 second step.
) (
  input wire sys_clk_i, // 250 MHz system clock.
  input wire reset_i, // Synchronous reset, active high.
  input wire psel_i, // APB select.
  input wire penable_i, // APB enable.
  input wire pwrite_i, // APB write direction.
  input wire [11:0] paddr_i, // APB byte address.
  input wire [31:0] pwdata_i, // APB write data.
  output reg [31:0] prdata_o, // APB read data.
  output reg pready_o, // APB ready.
  output reg pslverr_o, // APB error for unmapped address.
  input wire avg_valid_i, // One cycle strobe per line cycle.
  input wire [9:0] avg_current_i, // Cycle average in percent of rated full load current.
  input wire [3:0] starter_state_i, // One-hot operating state, asynchronous.
  input wire fault_clear_i, // External fault reset, asynchronous level.
  output reg [5:0] relay_o, // Relay energize outputs.
  output reg [7:0] fault_code_o, // Latched fault code, zero when none.
  output reg tripped_o, // High while a trip is latched.
  output reg oc_alarm_o, // Over current alarm.
  output reg uc_alarm_o, // Under current alarm.
  output reg irq_o // Level interrupt.
);

  // Range check shared by both level settings and both delay settings.
  function [9:0] clamp_setting;
    input [9:0] value;
    input [9:0] lo;
    input [9:0] hi;
    begin
      if (value == 10'h000) begin
        clamp_setting = 10'h000;
      end else if (value < lo) begin
        clamp_setting = lo;
      end else if (value > hi) begin
        clamp_setting = hi;
      end else begin
        clamp_setting = value;
      end
    end
  endfunction

  // Registers written by software.
  reg [9:0] oc_level_reg; // Over current level, zero is Off.
  reg [9:0] oc_delay_reg; // Over current delay in tenths of a second.
  reg [9:0] uc_level_reg; // Under current level, zero is Off.
  reg [9:0] uc_delay_reg; // Under current delay in tenths of a second.
  reg [15:0] relay_cfg_reg; // Alarm and fault duty selection per relay.
  reg [3:0] irq_mask_reg; // Interrupt enable per event.
  reg [3:0] irq_status_reg; // Sticky event bits.
  reg [3:0] irq_status_next; // Next sticky event bits.

  // Synchronisers for the asynchronous inputs.
  reg [3:0] state_meta_reg; // First stage, read only by the second.
  reg [3:0] state_sync_reg; // Stable operating state.
  reg clear_meta_reg; // First stage of the fault clear.
  reg clear_sync_reg; // Stable fault clear.

  // Protection state.
  reg oc_breach_reg; // Latest cycle average above the over level.
  reg uc_breach_reg; // Latest cycle average below the under level.
  reg trip_reg; // Trip latched.
  reg [31:0] tick_cnt_reg; // Counts clocks within a 0.1 s step.
  reg tick_reg; // One cycle pulse every 0.1 s.
  wire oc_expired; // Over current timer ran out.
  wire uc_expired; // Under current timer ran out.

  wire run_state = |state_sync_reg; // Any of the four running states.
  wire apb_access = psel_i && penable_i; // Access phase.
  wire apb_write = apb_access && pwrite_i && !pready_o; // Write takes effect once.
  wire [9:0] wdata10 = pwdata_i[9:0]; // Low bits of the write word.
  wire [3:0] oc_events = {1'b0, oc_expired && !trip_reg, 1'b0, 1'b0};

  // Two flip-flop synchronisers; the first stage feeds nothing else.
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      state_meta_reg <= 4'h0;
      state_sync_reg <= 4'h0;
      clear_meta_reg <= 1'b0;
      clear_sync_reg <= 1'b0;
    end else begin
      state_meta_reg <= starter_state_i;
      state_sync_reg <= state_meta_reg;
      clear_meta_reg <= fault_clear_i;
      clear_sync_reg <= clear_meta_reg;
    end
  end

  // Free running 0.1 s tick; the period is a parameter so that a
  // simulation can shorten it without touching the timers.
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      tick_cnt_reg <= 32'h00000000;
      tick_reg <= 1'b0;
    end else if (tick_cnt_reg >= TICK_CYCLES - 32'h00000001) begin
      tick_cnt_reg <= 32'h00000000;
      tick_reg <= 1'b1; // see RL17
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
      tick_reg <= 1'b0;
    end
  end

  // Once per line cycle the average is compared to both levels. Outside
  // the running states or with a level Off, the breach is dropped, which
  // also resets the matching timer.
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      oc_breach_reg <= 1'b0;
      uc_breach_reg <= 1'b0;
    end else if (!run_state) begin
      oc_breach_reg <= 1'b0; // see RL4
      uc_breach_reg <= 1'b0; // see RL12
    end else if (avg_valid_i) begin
      // Over check, disabled when the level is Off.
      oc_breach_reg <= (oc_level_reg != `LEVEL_OFF) &&
                       (avg_current_i > oc_level_reg); // see RL1, see RL5
      // Under check, disabled when the level is Off.
      uc_breach_reg <= (uc_level_reg != `LEVEL_OFF) &&
                       (avg_current_i < uc_level_reg); // see RL10, see RL13
    end
  end

  // Over current delay timer; a zero delay means Off and never expires.
  delay_timer oc_timer (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .breach_i(oc_breach_reg),
    .tick_i(tick_reg),
    .delay_i(oc_delay_reg),
    .expired_o(oc_expired)
  );

  // Under current delay timer with the same behaviour.
  delay_timer uc_timer (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .breach_i(uc_breach_reg),
    .tick_i(tick_reg),
    .delay_i(uc_delay_reg),
    .expired_o(uc_expired)
  );

  // Trip latch. The first expiring timer wins and its code stays until
  // the external clear; over current is preferred if both expire together.
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      trip_reg <= 1'b0;
      fault_code_o <= `FAULT_NONE;
    end else if (!trip_reg && oc_expired) begin
      trip_reg <= 1'b1;
      fault_code_o <= `OC_FAULT_CODE; // see RL3
    end else if (!trip_reg && uc_expired) begin
      trip_reg <= 1'b1;
      fault_code_o <= `UC_FAULT_CODE; // see RL11
    end else if (clear_sync_reg) begin
      trip_reg <= 1'b0; // see RL18
      fault_code_o <= `FAULT_NONE;
    end
  end

  // Alarm and relay outputs, all registered. An alarm relay follows the
  // breach, so with an Off delay it holds for as long as the breach lasts.
  // A fault relay switches state when a trip is latched.
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      oc_alarm_o <= 1'b0;
      uc_alarm_o <= 1'b0;
      tripped_o <= 1'b0;
      relay_o <= 6'h00;
    end else begin
      oc_alarm_o <= oc_breach_reg; // see RL2, see RL8
      uc_alarm_o <= uc_breach_reg; // see RL10, see RL16
      tripped_o <= trip_reg;
      relay_o <= (relay_cfg_reg[`RELAY_ALARM_LSB +: `RELAY_CNT] &
                  {6{oc_breach_reg | uc_breach_reg}}) ^
                 (relay_cfg_reg[`RELAY_FAULT_LSB +: `RELAY_CNT] &
                  {6{trip_reg}}); // see RL2, see RL14
    end
  end

  // Sticky event bits: a new event wins over a write-one clear.
  always @* begin
    irq_status_next = irq_status_reg;
    if (apb_write && paddr_i == `IRQ_STATUS_OFS) begin
      irq_status_next = irq_status_reg & ~pwdata_i[3:0];
    end
    irq_status_next[`EV_OC_ALARM] = irq_status_next[`EV_OC_ALARM] |
                                    (oc_breach_reg & ~oc_alarm_o);
    irq_status_next[`EV_UC_ALARM] = irq_status_next[`EV_UC_ALARM] |
                                    (uc_breach_reg & ~uc_alarm_o);
    irq_status_next = irq_status_next | oc_events;
    irq_status_next[`EV_UC_TRIP] = irq_status_next[`EV_UC_TRIP] |
                                   (uc_expired & ~trip_reg & ~oc_expired);
  end

  // Interrupt status and the level interrupt output.
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      irq_status_reg <= 4'h0;
      irq_o <= 1'b0;
    end else begin
      irq_status_reg <= irq_status_next;
      irq_o <= |(irq_status_next & irq_mask_reg);
    end
  end

  // APB slave: every access completes one cycle after the access phase
  // starts. Settings out of range are pulled to the nearest legal value,
  // so a zero delay written as a shear pin request still means Off; the
  // operator chooses the smallest legal step instead.
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      oc_level_reg <= `OC_LEVEL_RST; // see RL5
      oc_delay_reg <= `DELAY_RST; // see RL6
      uc_level_reg <= `UC_LEVEL_RST; // see RL13
      uc_delay_reg <= `DELAY_RST; // see RL15
      relay_cfg_reg <= `RELAY_CFG_RST;
      irq_mask_reg <= 4'h0;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h00000000;
    end else begin
      pready_o <= apb_access && !pready_o;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h00000000;
      if (apb_access && !pready_o) begin
        case (paddr_i)
          `OC_LEVEL_OFS: begin
            prdata_o <= {22'h000000, oc_level_reg};
            if (pwrite_i) begin
              oc_level_reg <= clamp_setting(wdata10, `OC_LEVEL_MIN, `OC_LEVEL_MAX); // see RL5
            end
          end
          `OC_DELAY_OFS: begin
            prdata_o <= {22'h000000, oc_delay_reg};
            if (pwrite_i) begin
              oc_delay_reg <= clamp_setting(wdata10, `DELAY_MIN, `DELAY_MAX); // see RL6
            end
          end
          `UC_LEVEL_OFS: begin
            prdata_o <= {22'h000000, uc_level_reg};
            if (pwrite_i) begin
              uc_level_reg <= clamp_setting(wdata10, `UC_LEVEL_MIN, `UC_LEVEL_MAX); // see RL13
            end
          end
          `UC_DELAY_OFS: begin
            prdata_o <= {22'h000000, uc_delay_reg};
            if (pwrite_i) begin
              uc_delay_reg <= clamp_setting(wdata10, `DELAY_MIN, `DELAY_MAX); // see RL15
            end
          end
          `RELAY_CFG_OFS: begin
            prdata_o <= {16'h0000, relay_cfg_reg};
            if (pwrite_i) begin
              relay_cfg_reg <= pwdata_i[15:0] & 16'h3F3F;
            end
          end
          `STATUS_OFS: begin
            // Live state for software: state, breaches, trip, code.
            prdata_o <= {16'h0000, fault_code_o, state_sync_reg, trip_reg,
                         uc_breach_reg, oc_breach_reg, run_state};
          end
          `IRQ_STATUS_OFS: begin
            prdata_o <= {28'h0000000, irq_status_reg};
          end
          `IRQ_MASK_OFS: begin
            prdata_o <= {28'h0000000, irq_mask_reg};
            if (pwrite_i) begin
              irq_mask_reg <= pwdata_i[3:0];
            end
          end
          `FAULT_CLEAR_OFS: begin
            prdata_o <= 32'h00000000;
          end
          default: begin
            pslverr_o <= 1'b1; // Unmapped address.
          end
        endcase
      end
    end
  end

endmodule

// *** tb/current_limit_protect_chk.sv ***
// Port assertions for the current limit protection block.
// Assumes the bind below and the register header on the include path.
`timescale 1ns/100ps
`include "current_limit_regs.vh"

module current_limit_protect_chk #(
  parameter [31:0] TICK_CYCLES = 32'h0000000A // Clocks per step, unused here.
) (
  input wire sys_clk_i, // Clock.
  input wire reset_i, // Reset.
  input wire psel_i, // Select.
  input wire penable_i, // Enable.
  input wire [31:0] prdata_o, // Read data.
  input wire pready_o, // Ready.
  input wire pslverr_o, // Error.
  input wire avg_valid_i, // Average strobe.
  input wire [3:0] starter_state_i, // Running state.
  input wire fault_clear_i, // Fault clear.
  input wire [7:0] fault_code_o, // Fault code.
  input wire tripped_o, // Trip latched.
  input wire oc_alarm_o, // Over alarm.
  input wire uc_alarm_o // Under alarm.
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  // An access phase still waiting for its answer.
  sequence s_access;
    psel_i && penable_i && !pready_o;
  endsequence
  // Long enough out of every running state to pass the synchroniser.
  sequence s_stopped;
    (starter_state_i == 4'h0) [*6];
  endsequence
  // Eight quiet cycles; one tick step of the bench is longer than that.
  sequence s_untripped;
    (!tripped_o) [*8];
  endsequence
  chk_ready_next: assert property (s_access |=> pready_o)
    else $error("ready did not follow the access phase");
  chk_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready held for two cycles");
  chk_rdata_quiet: assert property (!pready_o |-> prdata_o == 32'h00000000)
    else $error("read data outside the answer");
  chk_err_ready: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  chk_oc_strobe: assert property ($rose(oc_alarm_o) |-> $past(avg_valid_i, 2))
    else $error("over alarm without a strobe");
  chk_uc_strobe: assert property ($rose(uc_alarm_o) |-> $past(avg_valid_i, 2))
    else $error("under alarm without a strobe");
  chk_uc_no_early: assert property ($rose(uc_alarm_o) && !tripped_o |=> s_untripped)
    else $error("under trip before a full delay step");
  chk_run_gate: assert property (s_stopped |-> !oc_alarm_o && !uc_alarm_o)
    else $error("alarm while stopped");
  chk_fault_code: assert property (fault_code_o inside {8'h00, 8'h1F, 8'h22})
    else $error("unknown fault code");
  chk_trip_code: assert property ($rose(tripped_o) |-> $past(fault_code_o) != `FAULT_NONE)
    else $error("trip without fault code");
  chk_trip_hold: assert property ($fell(tripped_o) |->
    $past(fault_clear_i, 3) || $past(fault_clear_i, 4) || $past(fault_clear_i, 5))
    else $error("trip dropped without a clear");
endmodule

bind current_limit_protect current_limit_protect_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .sys_clk_i(sys_clk_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .avg_valid_i(avg_valid_i), .starter_state_i(starter_state_i),
  .fault_clear_i(fault_clear_i), .fault_code_o(fault_code_o), .tripped_o(tripped_o),
  .oc_alarm_o(oc_alarm_o), .uc_alarm_o(uc_alarm_o));

// *** tb/current_sense_model.sv ***
// Model of the current sensing and starter state logic.
// Assumes the same clock as the block; one strobe every eight clocks.
`timescale 1ns/100ps

module current_sense_model (
  input wire sys_clk_i, // Clock.
  input wire reset_i, // Reset.
  input wire running_i, // Motor is in a running state.
  input wire [9:0] value_i, // Average to report.
  output reg avg_valid_o, // Line cycle strobe.
  output reg [9:0] avg_current_o, // Average word.
  output reg [3:0] starter_state_o // One-hot state.
);
  reg [2:0] cnt_reg; // Clocks within a line cycle.
  reg [3:0] mode_reg; // Running mode, walks through all four.
  // Between strobes the word inverts every clock, so a sample one clock late is caught.
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      cnt_reg <= 3'h0;
      mode_reg <= 4'h1;
      avg_valid_o <= 1'b0;
      avg_current_o <= 10'h3FF;
      starter_state_o <= 4'h0;
    end else begin
      cnt_reg <= cnt_reg + 3'h1;
      avg_valid_o <= (cnt_reg == 3'h7);
      avg_current_o <= (cnt_reg == 3'h7) ? value_i : ~avg_current_o;
      if (avg_valid_o) begin
        mode_reg <= {mode_reg[2:0], mode_reg[3]};
      end
      starter_state_o <= running_i ? mode_reg : 4'h0;
    end
  end
endmodule

// *** tb/tb_motor_current_limit_protection.sv ***
// Self-checking bench for the current limit protection block.
// Assumes the register header on the include path and a short tick.
`timescale 1ns/100ps
`include "current_limit_regs.vh"

module tb_motor_current_limit_protection;
  localparam int LIMIT = 6000; // Cycle ceiling; the run needs about 1000.
  reg sys_clk_i = 1'b0;
  reg reset_i = 1'b1;
  reg psel_i = 1'b0;
  reg penable_i = 1'b0;
  reg pwrite_i = 1'b0;
  reg [11:0] paddr_i = 12'h000;
  reg [31:0] pwdata_i = 32'h00000000;
  reg fault_clear_i = 1'b0;
  reg running = 1'b0;
  reg [9:0] value = 10'h000;
  wire [31:0] prdata_o;
  wire pready_o, pslverr_o, avg_valid_i, tripped_o, oc_alarm_o, uc_alarm_o, irq_o;
  wire [9:0] avg_current_i;
  wire [3:0] starter_state_i;
  wire [5:0] relay_o;
  wire [7:0] fault_code_o;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [31:0] rd;
  logic err;

  initial begin
    forever #2 sys_clk_i = ~sys_clk_i;
  end

  current_limit_protect #(.TICK_CYCLES(32'h0000000A)) u_dut (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .avg_valid_i(avg_valid_i),
    .avg_current_i(avg_current_i), .starter_state_i(starter_state_i),
    .fault_clear_i(fault_clear_i), .relay_o(relay_o), .fault_code_o(fault_code_o),
    .tripped_o(tripped_o), .oc_alarm_o(oc_alarm_o), .uc_alarm_o(uc_alarm_o), .irq_o(irq_o));

  current_sense_model u_sense (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .running_i(running), .value_i(value),
    .avg_valid_o(avg_valid_i), .avg_current_o(avg_current_i),
    .starter_state_o(starter_state_i));

  task summarize;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task check(input [31:0] seen, input [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; waits for ready without assuming a latency.
  task apb(input logic wr, input [11:0] addr, input [31:0] data);
    @(posedge sys_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= addr;
    pwdata_i <= data;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    // Ready or the bench's cycle ceiling ends this wait.
    do begin
      @(posedge sys_clk_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task rdchk(input [11:0] addr, input [31:0] exp);
    apb(1'b0, addr, 32'h00000000);
    check(rd, exp);
  endtask

  task wrrd(input [11:0] addr, input [31:0] data, input [31:0] exp);
    apb(1'b1, addr, data);
    rdchk(addr, exp);
  endtask

  task wait_trip;
    while (tripped_o !== 1'b1) begin
      @(posedge sys_clk_i);
    end
  endtask

  // Reset values, then clamping of out of range settings and a bad address.
  task s_settings;
    rdchk(`OC_LEVEL_OFS, 32'h00000000);
    rdchk(`OC_DELAY_OFS, 32'h00000001);
    rdchk(`UC_LEVEL_OFS, 32'h00000000);
    rdchk(`UC_DELAY_OFS, 32'h00000001);
    wrrd(`OC_LEVEL_OFS, 32'h0000000A, 32'h00000032);
    wrrd(`OC_LEVEL_OFS, 32'h00000384, 32'h00000320);
    wrrd(`UC_LEVEL_OFS, 32'h00000002, 32'h00000005);
    wrrd(`UC_LEVEL_OFS, 32'h000000C8, 32'h00000064);
    wrrd(`OC_DELAY_OFS, 32'h000003E8, 32'h00000384);
    wrrd(`UC_DELAY_OFS, 32'h00000000, 32'h00000000);
    apb(1'b0, 12'h040, 32'h00000000);
    check({31'h0, err}, 32'h00000001);
  endtask

  // Breach while stopped is ignored; once running it alarms, then trips.
  task s_oc_trip;
    apb(1'b1, `UC_LEVEL_OFS, 32'h00000000);
    apb(1'b1, `OC_LEVEL_OFS, 32'h00000064);
    apb(1'b1, `OC_DELAY_OFS, 32'h00000003);
    apb(1'b1, `RELAY_CFG_OFS, 32'h00000201);
    rdchk(`RELAY_CFG_OFS, 32'h00000201);
    value <= 10'h0C8;
    repeat (60) @(posedge sys_clk_i);
    check({31'h0, oc_alarm_o}, 32'h00000000);
    running <= 1'b1;
    repeat (20) @(posedge sys_clk_i);
    check({31'h0, oc_alarm_o}, 32'h00000001);
    check({26'h0, relay_o}, 32'h00000001);
    check({31'h0, tripped_o}, 32'h00000000);
    wait_trip;
    check({24'h0, fault_code_o}, 32'h0000001F);
    repeat (2) @(posedge sys_clk_i);
    check({26'h0, relay_o}, 32'h00000003);
    check({31'h0, irq_o}, 32'h00000000);
    rdchk(`IRQ_STATUS_OFS, 32'h00000005);
    apb(1'b1, `IRQ_MASK_OFS, 32'h0000000F);
    repeat (2) @(posedge sys_clk_i);
    check({31'h0, irq_o}, 32'h00000001);
    apb(1'b1, `IRQ_STATUS_OFS, 32'h0000000F);
    repeat (2) @(posedge sys_clk_i);
    check({31'h0, irq_o}, 32'h00000000);
    value <= 10'h064;
    repeat (20) @(posedge sys_clk_i);
    check({31'h0, oc_alarm_o}, 32'h00000000);
    check({31'h0, tripped_o}, 32'h00000001);
    fault_clear_i <= 1'b1;
    repeat (10) @(posedge sys_clk_i);
    fault_clear_i <= 1'b0;
    check({31'h0, tripped_o}, 32'h00000000);
    check({26'h0, relay_o}, 32'h00000000);
  endtask

  // Interrupted breaches never add up to a trip; an Off delay never trips.
  task s_no_trip;
    apb(1'b1, `OC_DELAY_OFS, 32'h00000005);
    repeat (10) begin
      value <= 10'h0C8;
      repeat (24) @(posedge sys_clk_i);
      value <= 10'h032;
      repeat (16) @(posedge sys_clk_i);
    end
    check({31'h0, tripped_o}, 32'h00000000);
    apb(1'b1, `OC_DELAY_OFS, 32'h00000000);
    value <= 10'h0C8;
    repeat (200) @(posedge sys_clk_i);
    check({31'h0, tripped_o}, 32'h00000000);
    check({26'h0, relay_o}, 32'h00000001);
  endtask

  // Under current with an Off delay only alarms; the smallest delay trips.
  task s_uc_trip;
    apb(1'b1, `OC_LEVEL_OFS, 32'h00000000);
    apb(1'b1, `UC_LEVEL_OFS, 32'h00000032);
    apb(1'b1, `UC_DELAY_OFS, 32'h00000000);
    value <= 10'h014;
    repeat (100) @(posedge sys_clk_i);
    check({31'h0, tripped_o}, 32'h00000000);
    check({31'h0, uc_alarm_o}, 32'h00000001);
    value <= 10'h064;
    repeat (20) @(posedge sys_clk_i);
    check({31'h0, uc_alarm_o}, 32'h00000000);
    apb(1'b1, `UC_DELAY_OFS, 32'h00000001);
    value <= 10'h014;
    wait_trip;
    check({24'h0, fault_code_o}, 32'h00000022);
    repeat (2) @(posedge sys_clk_i);
    check({31'h0, uc_alarm_o}, 32'h00000001);
    check({26'h0, relay_o}, 32'h00000003);
    rdchk(`IRQ_STATUS_OFS, 32'h0000000B);
    apb(1'b0, `STATUS_OFS, 32'h00000000);
    check(rd & 32'h0000FF0F, 32'h0000220D);
  endtask

  initial begin
    repeat (6) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    s_settings;
    s_oc_trip;
    s_no_trip;
    s_uc_trip;
    summarize;
  end

  // A hang counts as a mismatch and ends the run.
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_mismatch++;
      summarize;
    end
  end
endmodule
